// file: lcr_consts.svh
// Constants of the link unit command responder
`ifndef LCR_CONSTS_SVH
`define LCR_CONSTS_SVH

// ----------------------------------------
// Command codes (first byte, second byte)
// ----------------------------------------
`define LCR_CMD_LINK 8'h04
`define LCR_CMD_LINK_START 8'h01
`define LCR_CMD_LINK_HALT 8'h02
`define LCR_CMD_UNIT_RESET 8'h03
`define LCR_CMD_DATA 8'h05
`define LCR_CMD_DATA_CTRL 8'h01
`define LCR_CMD_STAT 8'h06
`define LCR_CMD_STAT_CTRL 8'h01
`define LCR_CMD_STAT_NET 8'h02

// ----------------------------------------
// Main result codes
// ----------------------------------------
`define LCR_MAIN_NORMAL 8'h00
`define LCR_MAIN_LOCAL_NODE 8'h01
`define LCR_MAIN_DEST_NODE 8'h02
`define LCR_MAIN_CONTROLLER 8'h03
`define LCR_MAIN_NOT_EXEC 8'h04
`define LCR_MAIN_ROUTING 8'h05
`define LCR_MAIN_FORMAT 8'h10
`define LCR_MAIN_PARAMETER 8'h11
`define LCR_MAIN_READ_IMP 8'h20
`define LCR_MAIN_WRITE_IMP 8'h21
`define LCR_MAIN_WRONG_MODE 8'h22
`define LCR_MAIN_NO_UNIT 8'h23
`define LCR_MAIN_START_STOP 8'h24
`define LCR_MAIN_UNIT_FAULT 8'h25
`define LCR_MAIN_CMD_FAULT 8'h26
`define LCR_MAIN_ACCESS 8'h30

// ----------------------------------------
// Sub result codes
// ----------------------------------------
`define LCR_SUB_NORMAL 8'h00
`define LCR_SUB_UNDEFINED 8'h01
`define LCR_SUB_START_BAD 8'h01
`define LCR_SUB_HALT_BAD 8'h02

// ----------------------------------------
// Reply layout and field values
// ----------------------------------------
`define LCR_LEN_CODE 7'h02
`define LCR_LEN_CDATA 7'h2C
`define LCR_LEN_CSTAT 7'h19
`define LCR_LEN_NSTAT 7'h6C
`define LCR_REPLY_MAX 108
`define LCR_ASCII_LEN 20
`define LCR_ASCII_SPACE 8'h20
`define LCR_RAM_8K 3'h3
`define LCR_ERR_PARAM_BIT 2
`define LCR_NODES 62
`define LCR_MEMBER_BYTES 31
`define LCR_CYCLE_OFS 33
`define LCR_NONFATAL_OFS 38
`define LCR_CYCCNT_OFS 46
`define LCR_CNT_MAX 8'hFF

`endif

// file: lcr_host_model.sv
// Requesting host model that sinks reply bytes
`timescale 1ns/10ps

module lcr_host_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  output logic resp_ready
);
  logic [7:0] rx [0:127];
  logic [7:0] n = 8'h00;
  logic got_last = 1'b0;
  logic tgl = 1'b0;
  // Byte taken on edges with valid and ready high
  always @(posedge sys_clk) begin
    if (resp_valid && resp_ready) begin
      rx[n] = resp_data;
      n = n + 8'h01;
      got_last = resp_last;
    end
  end
  // Ready moves on falling edge; slow mode stalls every other cycle
  initial resp_ready = 1'b0;
  always @(negedge sys_clk) begin
    tgl = ~tgl;
    resp_ready = rst_b && (!slow || tgl);
  end
endmodule // lcr_host_model

// file: lcr_pkg.sv
// Types of the link unit command responder
package lcr_pkg;

  // Link word allocation method
  typedef enum logic [1:0] {
    lcr_alloc_auto,
    lcr_alloc_table,
    lcr_alloc_manual,
    lcr_alloc_none
  } lcr_alloc_t;

  typedef enum logic {lcr_st_idle, lcr_st_send} lcr_state_t;

  typedef enum logic [1:0] {
    lcr_rep_code,
    lcr_rep_cdata,
    lcr_rep_cstat,
    lcr_rep_nstat
  } lcr_rep_t;

  typedef struct packed {
    lcr_state_t state;
    lcr_rep_t rep;
    logic [6:0] idx;
    logic [6:0] len;
    logic [7:0] main_code;
    logic [7:0] sub_code;
    logic link_active;
    logic joined;
    logic param_err;
    logic cmd_ready;
    logic resp_valid;
    logic [7:0] resp_data;
    logic resp_last;
    logic unit_reset;
    logic params_store;
  } lcr_state_vec_t;

  typedef struct packed {
    logic [7:0] count;
  } lcr_cnt_state_t;

endpackage

// file: lcr_responder.sv
// Command responder of a token-passing network unit
`timescale 1ns/10ps
`include "lcr_consts.svh"

// Behaviour
// - Error-free command answers completion code 00 00
// - Completion code: main byte then sub byte
// - Main result byte uses the fixed encodings
// - Link start only with automatic or table allocation
// - Link halt only while link runs
// - Unit reset sends no reply at all
// - Model, version: 20 ASCII bytes, space padded
// - Cable byte bit 7 set for fibre
// - Cable byte bits 0-2 read 011
// - Own node address reported, 01 to 3E
// - Link state byte: 00 stopped, 01 active
// - First join parameter mismatch sets error bit 2
// - Eight event counters saturate at 255
// - Counter order fixed: CRC through controller stops
// - Participation bitmap, node n at bit n-1
// - Member data 31 bytes, odd node low nibble
// - Bit 1/5 gives absence reason when absent
// - Cycle time 16 bits in 100 us units
// - Current polling node address reported
// - Cyclic operation and transmission as 00/01
// - Non-fatal bitmap, node n at bit n
// - 62 cyclic error counters saturate at 255
module lcr_responder (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_main,
  input wire logic [7:0] cmd_sub,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic resp_last,
  input wire logic resp_ready,
  output logic unit_reset,
  output logic link_active,
  output logic params_store,
  input wire lcr_pkg::lcr_alloc_t link_alloc_mode,
  input wire logic net_join,
  input wire logic params_differ,
  input wire logic [159:0] model_ascii,
  input wire logic [159:0] version_ascii,
  input wire logic cable_fibre,
  input wire logic [7:0] node_addr,
  input wire logic [47:0] status_bytes,
  input wire logic [7:0] event_pulse,
  input wire logic [61:0] node_present,
  input wire logic [61:0] node_absent_why,
  input wire logic [123:0] node_info,
  input wire logic [15:0] cycle_time,
  input wire logic [7:0] polling_node,
  input wire logic cyclic_on,
  input wire logic cyclic_tx,
  input wire logic [61:0] node_nonfatal,
  input wire logic [61:0] cyclic_err_pulse
);

  // ----------------------------------------
  // State and reply image
  // ----------------------------------------
  lcr_pkg::lcr_state_vec_t st;
  lcr_pkg::lcr_state_vec_t next_st;
  logic [7:0] rb [0:`LCR_REPLY_MAX-1];
  logic [7:0] event_cnt [0:7];
  logic [7:0] cyc_cnt [0:`LCR_NODES-1];
  logic [63:0] part_map;
  logic [63:0] nonfatal_map;
  logic [247:0] member_map;
  logic [7:0] status3;

  // ----------------------------------------
  // Saturating counters
  // ----------------------------------------
  // Event counters, order set by event_pulse bit
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_event
      lcr_sat_counter u_cnt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .bump(event_pulse[g]),
        .count(event_cnt[g])
      );
    end
    // Per-node cyclic error counters
    for (g = 0; g < `LCR_NODES; g++) begin : g_cyclic
      lcr_sat_counter u_cnt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .bump(cyclic_err_pulse[g]),
        .count(cyc_cnt[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Bitmaps and member data
  // ----------------------------------------
  // Node n at bit n-1, top two bits zero
  assign part_map = {2'b00, node_present};
  // Node n at bit n, bits 0 and 63 zero
  assign nonfatal_map = {1'b0, node_nonfatal, 1'b0};
  // Mismatch flag merged into the error status byte
  always_comb begin
    status3 = status_bytes[23:16];
    status3[`LCR_ERR_PARAM_BIT] = status_bytes[16+`LCR_ERR_PARAM_BIT] | st.param_err;
  end

  // One nibble per node, odd node in the low nibble
  always_comb begin
    member_map = '0;
    for (int n = 0; n < `LCR_NODES; n++) begin
      member_map[4*n] = node_present[n];
      member_map[4*n+1] = ~node_present[n] & node_absent_why[n];
      member_map[4*n+2] = node_info[2*n];
      member_map[4*n+3] = node_info[2*n+1];
    end
  end

  // ----------------------------------------
  // Reply byte image
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < `LCR_REPLY_MAX; i++) begin
      rb[i] = 8'h00;
    end
    // Completion code leads every reply
    rb[0] = st.main_code;
    rb[1] = st.sub_code;
    unique case (st.rep)
      lcr_pkg::lcr_rep_code: begin
        rb[0] = st.main_code;
      end
      lcr_pkg::lcr_rep_cdata: begin
        // Model and version, zero bytes become spaces
        for (int i = 0; i < `LCR_ASCII_LEN; i++) begin
          rb[2+i] = (model_ascii[8*i+:8] == 8'h00) ?
                    `LCR_ASCII_SPACE : model_ascii[8*i+:8];
          rb[2+`LCR_ASCII_LEN+i] = (version_ascii[8*i+:8] == 8'h00) ?
                    `LCR_ASCII_SPACE : version_ascii[8*i+:8];
        end
        rb[42] = {cable_fibre, 4'h0, `LCR_RAM_8K};
        rb[43] = node_addr;
      end
      lcr_pkg::lcr_rep_cstat: begin
        rb[2] = {7'h00, st.link_active};
        for (int i = 0; i < 6; i++) begin
          rb[3+i] = (i == 2) ? status3 : status_bytes[8*i+:8];
        end
        for (int i = 0; i < 8; i++) begin
          rb[9+i] = event_cnt[i];
          rb[17+i] = part_map[8*i+:8];
        end
      end
      lcr_pkg::lcr_rep_nstat: begin
        for (int i = 0; i < `LCR_MEMBER_BYTES; i++) begin
          rb[2+i] = member_map[8*i+:8];
        end
        rb[`LCR_CYCLE_OFS] = cycle_time[15:8];
        rb[`LCR_CYCLE_OFS+1] = cycle_time[7:0];
        rb[`LCR_CYCLE_OFS+2] = polling_node;
        rb[`LCR_CYCLE_OFS+3] = {7'h00, cyclic_on};
        rb[`LCR_CYCLE_OFS+4] = {7'h00, cyclic_tx};
        for (int i = 0; i < 8; i++) begin
          rb[`LCR_NONFATAL_OFS+i] = nonfatal_map[8*i+:8];
        end
        for (int i = 0; i < `LCR_NODES; i++) begin
          rb[`LCR_CYCCNT_OFS+i] = cyc_cnt[i];
        end
      end
    endcase
  end

  // ----------------------------------------
  // Command decode and reply sequencing
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.unit_reset = 1'b0;
    next_st.params_store = 1'b0;
    // First join after power-up: on mismatch, flag and store live set
    if (net_join && !st.joined) begin
      next_st.joined = 1'b1;
      if (params_differ) begin
        next_st.param_err = 1'b1;
        next_st.params_store = 1'b1;
      end
    end
    unique case (st.state)
      lcr_pkg::lcr_st_idle: begin
        if (cmd_valid) begin
          next_st.state = lcr_pkg::lcr_st_send;
          next_st.cmd_ready = 1'b0;
          next_st.idx = 7'h00;
          next_st.rep = lcr_pkg::lcr_rep_code;
          next_st.len = `LCR_LEN_CODE;
          next_st.main_code = `LCR_MAIN_NORMAL;
          next_st.sub_code = `LCR_SUB_NORMAL;
          if (cmd_main == `LCR_CMD_LINK && cmd_sub == `LCR_CMD_LINK_START) begin
            // Start only with automatic or table allocation
            if (link_alloc_mode == lcr_pkg::lcr_alloc_auto ||
                link_alloc_mode == lcr_pkg::lcr_alloc_table) begin
              next_st.link_active = 1'b1;
            end else begin
              next_st.main_code = `LCR_MAIN_WRONG_MODE;
              next_st.sub_code = `LCR_SUB_START_BAD;
            end
          end else if (cmd_main == `LCR_CMD_LINK && cmd_sub == `LCR_CMD_LINK_HALT) begin
            // Halt only a running link
            if (st.link_active) begin
              next_st.link_active = 1'b0;
            end else begin
              next_st.main_code = `LCR_MAIN_WRONG_MODE;
              next_st.sub_code = `LCR_SUB_HALT_BAD;
            end
          end else if (cmd_main == `LCR_CMD_LINK && cmd_sub == `LCR_CMD_UNIT_RESET) begin
            // Reset the unit, answer nothing
            next_st.state = lcr_pkg::lcr_st_idle;
            next_st.cmd_ready = 1'b1;
            next_st.unit_reset = 1'b1;
            next_st.link_active = 1'b0;
          end else if (cmd_main == `LCR_CMD_DATA && cmd_sub == `LCR_CMD_DATA_CTRL) begin
            next_st.rep = lcr_pkg::lcr_rep_cdata;
            next_st.len = `LCR_LEN_CDATA;
          end else if (cmd_main == `LCR_CMD_STAT && cmd_sub == `LCR_CMD_STAT_CTRL) begin
            next_st.rep = lcr_pkg::lcr_rep_cstat;
            next_st.len = `LCR_LEN_CSTAT;
          end else if (cmd_main == `LCR_CMD_STAT && cmd_sub == `LCR_CMD_STAT_NET) begin
            next_st.rep = lcr_pkg::lcr_rep_nstat;
            next_st.len = `LCR_LEN_NSTAT;
          end else begin
            // Unsupported command
            next_st.main_code = `LCR_MAIN_NOT_EXEC;
            next_st.sub_code = `LCR_SUB_UNDEFINED;
          end
        end
      end
      lcr_pkg::lcr_st_send: begin
        // Advance when the output byte is free or taken
        if (!st.resp_valid || resp_ready) begin
          if (st.idx < st.len) begin
            next_st.resp_valid = 1'b1;
            next_st.resp_data = rb[st.idx];
            next_st.resp_last = (st.idx == st.len - 7'h01);
            next_st.idx = st.idx + 7'h01;
          end else begin
            next_st.resp_valid = 1'b0;
            next_st.resp_last = 1'b0;
            next_st.state = lcr_pkg::lcr_st_idle;
            next_st.cmd_ready = 1'b1;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.state <= lcr_pkg::lcr_st_idle;
      st.rep <= lcr_pkg::lcr_rep_code;
      st.cmd_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign cmd_ready = st.cmd_ready;
  assign resp_valid = st.resp_valid;
  assign resp_data = st.resp_data;
  assign resp_last = st.resp_last;
  assign unit_reset = st.unit_reset;
  assign link_active = st.link_active;
  assign params_store = st.params_store;

endmodule // lcr_responder

// file: lcr_responder_props.sv
// Checker of the link unit command responder port behaviour
`timescale 1ns/10ps

module lcr_responder_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_main,
  input wire logic [7:0] cmd_sub,
  input wire logic cmd_ready,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  input wire logic resp_last,
  input wire logic resp_ready,
  input wire logic unit_reset,
  input wire logic link_active,
  input wire logic params_store,
  input wire logic net_join,
  input wire lcr_pkg::lcr_alloc_t link_alloc_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic take, lnk, rst_cmd, ok_alloc;
  // Command taken and its decode
  assign take = cmd_valid && cmd_ready;
  assign lnk = take && cmd_main == 8'h04;
  assign rst_cmd = lnk && cmd_sub == 8'h03;
  assign ok_alloc = link_alloc_mode inside {lcr_pkg::lcr_alloc_auto, lcr_pkg::lcr_alloc_table};

  AST_ANSWER: assert property (take && !rst_cmd |=> !cmd_ready ##1 resp_valid)
    else $error("reply did not start two edges after command");
  AST_NO_REPLY: assert property (rst_cmd |=> unit_reset && !resp_valid ##1 !resp_valid [*4])
    else $error("reset command gave a reply or no reset pulse");
  AST_HOLD: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_data)
    && $stable(resp_last))
    else $error("reply byte changed before it was taken");
  AST_BUSY: assert property (resp_valid |-> !cmd_ready)
    else $error("ready for commands while reply pending");
  AST_START: assert property (lnk && cmd_sub == 8'h01 && ok_alloc |-> ##[1:3] link_active)
    else $error("link did not start");
  AST_START_BAD: assert property (lnk && cmd_sub == 8'h01 && !ok_alloc && !link_active
    |=> ##1 resp_data == 8'h22 && !link_active)
    else $error("link start with wrong allocation not refused");
  AST_HALT_IDLE: assert property (lnk && cmd_sub == 8'h02 && !link_active
    |=> ##1 resp_valid && resp_data == 8'h22)
    else $error("halt of stopped link not refused");
  AST_HALT: assert property (lnk && cmd_sub == 8'h02 && link_active |-> ##[1:3] !link_active)
    else $error("link did not halt");
  AST_PULSE: assert property (unit_reset || params_store |=> !unit_reset && !params_store)
    else $error("side pulse longer than one cycle");
  AST_STORE: assert property (params_store |-> $past(net_join))
    else $error("parameter store without join");

  // Main scenarios
  CV_NSTAT: cover property (take && cmd_main == 8'h06 && cmd_sub == 8'h02);
  CV_STALL: cover property (resp_valid && !resp_ready);
  CV_RESET: cover property (unit_reset);
endmodule // lcr_responder_props

bind lcr_responder lcr_responder_props props_u (.sys_clk, .rst_b, .cmd_valid, .cmd_main,
  .cmd_sub, .cmd_ready, .resp_valid, .resp_data, .resp_last, .resp_ready, .unit_reset,
  .link_active, .params_store, .net_join, .link_alloc_mode);

// file: lcr_responder_tb.sv
// Self-checking bench of the link unit command responder
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module lcr_responder_tb;
  logic sys_clk, rst_b = 1'b0, cmd_valid = 1'b0, slow = 1'b0, net_join = 1'b0;
  logic [7:0] cmd_main = 8'h00, cmd_sub = 8'h00, event_pulse = 8'h00, resp_data;
  logic cmd_ready, resp_valid, resp_last, resp_ready, unit_reset, link_active, params_store;
  lcr_pkg::lcr_alloc_t link_alloc_mode = lcr_pkg::lcr_alloc_auto;
  logic params_differ = 1'b1, cable_fibre = 1'b1, cyclic_on = 1'b1, cyclic_tx = 1'b0;
  logic [159:0] model_ascii = 160'h4241, version_ascii = 160'h31;
  logic [7:0] node_addr = 8'h3E, polling_node = 8'h05;
  logic [47:0] status_bytes = 48'h0;
  logic [61:0] node_present = 62'h2000_0000_0000_0005, node_absent_why = 62'h2;
  logic [61:0] node_nonfatal = 62'h2000_0000_0000_0001, cyclic_err_pulse = 62'h0;
  logic [123:0] node_info = 124'h0;
  logic [15:0] cycle_time = 16'h1234;
  int num_errors = 0, n_tests = 0;
  logic saw_reset = 1'b0;
  // Rows: alloc, command, reply length, completion code
  localparam logic [41:0] ROWS [10] = '{
    {2'h0, 16'h0402, 8'h02, 16'h2202}, {2'h2, 16'h0401, 8'h02, 16'h2201},
    {2'h0, 16'h0401, 8'h02, 16'h0000}, {2'h1, 16'h0401, 8'h02, 16'h0000},
    {2'h1, 16'h0402, 8'h02, 16'h0000}, {2'h1, 16'h0401, 8'h02, 16'h0000},
    {2'h3, 16'h0501, 8'h2C, 16'h0000}, {2'h3, 16'h0601, 8'h19, 16'h0000},
    {2'h3, 16'h0602, 8'h6C, 16'h0000}, {2'h3, 16'h0101, 8'h02, 16'h0401}};

  lcr_responder dut_u (.sys_clk, .rst_b, .cmd_valid, .cmd_main, .cmd_sub, .cmd_ready,
    .resp_valid, .resp_data, .resp_last, .resp_ready, .unit_reset, .link_active,
    .params_store, .link_alloc_mode, .net_join, .params_differ, .model_ascii,
    .version_ascii, .cable_fibre, .node_addr, .status_bytes, .event_pulse, .node_present,
    .node_absent_why, .node_info, .cycle_time, .polling_node, .cyclic_on, .cyclic_tx,
    .node_nonfatal, .cyclic_err_pulse);
  lcr_host_model host_u (.sys_clk, .rst_b, .slow, .resp_valid, .resp_data, .resp_last,
    .resp_ready);

  // Verdict and end of run
  task automatic results();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One command, then wait for the whole reply
  task automatic run(input logic [7:0] m, input logic [7:0] s);
    int k;
    host_u.n = 8'h00;
    host_u.got_last = 1'b0;
    cmd_main = m;
    cmd_sub = s;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    saw_reset = unit_reset;
    cmd_valid = 1'b0;
    k = 0;
    while (!host_u.got_last && k < 300) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (2) @(negedge sys_clk);
  endtask

  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #400000;
    num_errors++;
    results();
  end

  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 10; i++) begin
      link_alloc_mode = lcr_pkg::lcr_alloc_t'(ROWS[i][41:40]);
      run(ROWS[i][39:32], ROWS[i][31:24]);
      `CHK(host_u.n, ROWS[i][23:16])
      `CHK({host_u.rx[0], host_u.rx[1]}, ROWS[i][15:0])
    end
    // Joins and event bursts past the counter top
    for (int i = 0; i < 300; i++) begin
      net_join = (i < 2);
      event_pulse = (i < 3) ? 8'h05 : 8'h01;
      cyclic_err_pulse = 62'h2;
      @(negedge sys_clk);
      if (i < 2) `CHK(params_store, (i == 0))
      net_join = 1'b0;
      event_pulse = 8'h00;
      cyclic_err_pulse = 62'h0;
      @(negedge sys_clk);
    end
    slow = 1'b1;
    run(8'h06, 8'h01);
    `CHK({host_u.rx[2], host_u.rx[5]}, 16'h0104)
    `CHK({host_u.rx[9], host_u.rx[10], host_u.rx[11]}, 24'hFF_0003)
    `CHK({host_u.rx[17], host_u.rx[24]}, 16'h0520)
    run(8'h06, 8'h02);
    `CHK({host_u.rx[2], host_u.rx[3]}, 16'h2101)
    `CHK({host_u.rx[33], host_u.rx[34], host_u.rx[35]}, 24'h12_3405)
    `CHK({host_u.rx[36], host_u.rx[37]}, 16'h0100)
    `CHK({host_u.rx[38], host_u.rx[45]}, 16'h0240)
    `CHK({host_u.rx[46], host_u.rx[47], host_u.n}, 24'h00_FF6C)
    slow = 1'b0;
    run(8'h05, 8'h01);
    `CHK({host_u.rx[2], host_u.rx[3], host_u.rx[4]}, 24'h41_4220)
    `CHK({host_u.rx[22], host_u.rx[23]}, 16'h3120)
    `CHK({host_u.rx[42], host_u.rx[43]}, 16'h833E)
    // Unit reset: silent, link stops, counters kept
    run(8'h04, 8'h03);
    `CHK({host_u.n, link_active, saw_reset}, 10'h001)
    run(8'h06, 8'h01);
    `CHK({host_u.rx[2], host_u.rx[9]}, 16'h00FF)
    // Power reset in mid-run clears counters and mismatch flag
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    run(8'h06, 8'h01);
    `CHK({host_u.rx[5], host_u.rx[9]}, 16'h0000)
    results();
  end
endmodule // lcr_responder_tb

// file: lcr_sat_counter.sv
// Eight-bit event counter that stops at its top value
`timescale 1ns/10ps
`include "lcr_consts.svh"

module lcr_sat_counter (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic bump,
  output logic [7:0] count
);

  lcr_pkg::lcr_cnt_state_t st;
  lcr_pkg::lcr_cnt_state_t next_st;

  // Count up, hold at the top
  always_comb begin
    next_st = st;
    if (bump && (st.count != `LCR_CNT_MAX)) begin
      next_st.count = st.count + 8'h01;
    end
  end

  // Cleared only by the power-on reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

endmodule // lcr_sat_counter
